// >>> hw/tsa_sequencer.sv
// Phase sequencer and result counter of the triple-slope converter
`include "tsa_defines.svh"

module tsa_sequencer #(
  parameter int INTEG_CYCLES  = `TSA_INTEG_CYCLES,
  parameter int SETTLE_CYCLES = `TSA_SETTLE_CYCLES
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 trigger_n_in,
  input  wire logic                 input_positive_in,
  input  wire logic                 preset_level_in,
  input  wire logic                 zero_return_input,
  output tsa_pkg::tsa_result_t      result_out,
  output tsa_pkg::tsa_switch_t      switch_out,
  output logic                      busy_out,
  output logic                      done_out
);

  // ==========================================================
  // Elaboration checks
  initial begin
    if (INTEG_CYCLES < 2 || INTEG_CYCLES > 1048575 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1048575) begin
      $error("tsa_sequencer: cycle counts out of range");
    end
  end

  localparam logic [19:0] INTEG_LAST  = 20'(INTEG_CYCLES - 1);
  localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_CYCLES - 1);

  // ==========================================================
  // Trigger edges
  tsa_pkg::tsa_state_t state;
  logic                trig_d;
  logic                trig_fall;
  logic                trig_rise;
  logic [19:0]         timer;
  logic                timer_done;
  logic [15:0]         count;
  logic                sign;

  assign trig_fall  = trig_d & ~trigger_n_in;
  assign trig_rise  = ~trig_d & trigger_n_in;
  assign timer_done = (state == tsa_pkg::TSA_INTEG) ? (timer == INTEG_LAST) : (timer == SETTLE_LAST);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trig_d <= 1'b1;
    end else begin
      trig_d <= trigger_n_in;
    end
  end

  // ==========================================================
  // Phase sequencer
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= tsa_pkg::TSA_ZERO;
    end else begin
      case (state)
        tsa_pkg::TSA_ZERO: begin
          // Triggers mid-conversion are ignored; the host must wait
          if (trig_rise) begin
            state <= tsa_pkg::TSA_INTEG;
          end
        end
        tsa_pkg::TSA_INTEG: begin
          if (timer_done) begin
            state <= tsa_pkg::TSA_PAUSE1;
          end
        end
        tsa_pkg::TSA_PAUSE1: begin
          if (timer_done) begin
            state <= tsa_pkg::TSA_FAST;
          end
        end
        tsa_pkg::TSA_FAST: begin
          if (preset_level_in) begin
            state <= tsa_pkg::TSA_PAUSE2;
          end
        end
        tsa_pkg::TSA_PAUSE2: begin
          if (timer_done) begin
            state <= tsa_pkg::TSA_SLOW;
          end
        end
        tsa_pkg::TSA_SLOW: begin
          if (zero_return_input) begin
            state <= tsa_pkg::TSA_ZERO;
          end
        end
        default: begin
          state <= tsa_pkg::TSA_ZERO;
        end
      endcase
    end
  end

  // ==========================================================
  // Phase timer, cycle based
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer <= 20'h0_0000;
    end else if ((state == tsa_pkg::TSA_INTEG || state == tsa_pkg::TSA_PAUSE1 ||
                  state == tsa_pkg::TSA_PAUSE2) && !timer_done) begin
      timer <= timer + 20'h0_0001;
    end else begin
      timer <= 20'h0_0000;
    end
  end

  // ==========================================================
  // Result counter
  // Fast phase adds at the coarse bit; saturates so full scale reads all ones
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 16'h0000;
      sign  <= 1'b0;
    end else if (state == tsa_pkg::TSA_ZERO && trig_fall) begin
      count <= 16'h0000;
    end else if (state == tsa_pkg::TSA_INTEG && timer_done) begin
      sign <= input_positive_in;
    end else if (state == tsa_pkg::TSA_FAST && !preset_level_in) begin
      if (count[15:`TSA_COARSE_BIT] != 9'h1FF) begin
        count <= count + (16'h0001 << `TSA_COARSE_BIT);
      end
    end else if (state == tsa_pkg::TSA_SLOW && !zero_return_input) begin
      if (count != 16'hFFFF) begin
        count <= count + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_out <= '0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (state == tsa_pkg::TSA_ZERO && trig_rise) begin
        busy_out <= 1'b1;
      end else if (state == tsa_pkg::TSA_SLOW && zero_return_input) begin
        result_out.sign <= sign;
        result_out.mag  <= count;
        busy_out        <= 1'b0;
        done_out        <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Idle is zero correction from the very first cycle
      switch_out <= 5'b1_0000;
    end else begin
      switch_out.zero_correction_phase <= (state == tsa_pkg::TSA_ZERO);
      switch_out.integrate_input       <= (state == tsa_pkg::TSA_INTEG);
      switch_out.ref_fast              <= (state == tsa_pkg::TSA_FAST);
      switch_out.ref_slow              <= (state == tsa_pkg::TSA_SLOW);
      // Discharge reference opposes the input polarity
      switch_out.ref_negative          <= sign;
    end
  end

endmodule // tsa_sequencer

// >>> hw/tsa_defines.svh
// Timing and width constants for the triple-slope converter sequencer
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH
`define TSA_CLK_MHZ         125
`define TSA_INTEG_TIME_US   640
`define TSA_INTEG_CYCLES    (`TSA_INTEG_TIME_US * `TSA_CLK_MHZ)
`define TSA_SETTLE_CYCLES   16
`define TSA_MAG_W           16
`define TSA_COARSE_BIT      7
`endif

// >>> hw/tsa_pkg.sv
// Types of the triple-slope converter sequencer
package tsa_pkg;
  typedef enum logic [5:0] {
    TSA_ZERO    = 6'b00_0001,
    TSA_INTEG   = 6'b00_0010,
    TSA_PAUSE1  = 6'b00_0100,
    TSA_FAST    = 6'b00_1000,
    TSA_PAUSE2  = 6'b01_0000,
    TSA_SLOW    = 6'b10_0000
  } tsa_state_t;

  typedef struct packed {
    logic        sign;
    logic [15:0] mag;
  } tsa_result_t;

  typedef struct packed {
    logic zero_correction_phase;
    logic integrate_input;
    logic ref_fast;
    logic ref_slow;
    logic ref_negative;
  } tsa_switch_t;
endpackage

// >>> test/tsa_asserts.sv
// Checker for the sequencer ports, bound below
module tsa_asserts #(
  parameter int INTEG_CYCLES  = 20,
  parameter int SETTLE_CYCLES = 2
) (
  input wire logic            sys_clk_in,
  input wire logic            rst_n_in,
  input wire logic            trigger_n_in,
  input wire logic            input_positive_in,
  input wire logic            preset_level_in,
  input wire logic            zero_return_input,
  input wire tsa_pkg::tsa_result_t result_out,
  input wire tsa_pkg::tsa_switch_t switch_out,
  input wire logic            busy_out,
  input wire logic            done_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  int n;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) n <= 0;
    else n <= switch_out.integrate_input ? n + 1 : 0;
  property p_start; $rose(trigger_n_in) && !busy_out && switch_out.zero_correction_phase |=> busy_out; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_integ; $rose(busy_out) |=> switch_out.integrate_input; endproperty
  a_integ: assert property (p_integ) else $error("no integrate");
  property p_len; $fell(switch_out.integrate_input) |-> n == INTEG_CYCLES; endproperty
  a_len: assert property (p_len) else $error("integrate length");
  property p_pause; $fell(switch_out.integrate_input) |-> !switch_out.ref_fast ##1 !switch_out.ref_fast; endproperty
  a_pause: assert property (p_pause) else $error("no pause");
  property p_hot; $onehot0(switch_out[4:1]); endproperty
  a_hot: assert property (p_hot) else $error("phase overlap");
  property p_done; done_out |-> !busy_out && $past(busy_out); endproperty
  a_done: assert property (p_done) else $error("done vs busy");
  property p_hold; !done_out |-> $stable(result_out); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_idle; !busy_out |=> switch_out.zero_correction_phase; endproperty
  a_idle: assert property (p_idle) else $error("idle not zeroing");
  c_done: cover property (done_out);
  c_fast: cover property ($rose(switch_out.ref_fast));
  c_slow: cover property ($rose(switch_out.ref_slow));
endmodule // tsa_asserts
bind tsa_sequencer tsa_asserts #(.INTEG_CYCLES(INTEG_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .trigger_n_in(trigger_n_in),
  .input_positive_in(input_positive_in), .preset_level_in(preset_level_in),
  .zero_return_input(zero_return_input), .result_out(result_out), .switch_out(switch_out),
  .busy_out(busy_out), .done_out(done_out));

// >>> test/tsa_front_model.sv
// Integrator front-end model feeding the sequencer
module tsa_front_model (
  input  wire logic          sys_clk_in,
  input  wire logic          full_in,
  input  wire logic          pos_in,
  input  tsa_pkg::tsa_switch_t sw_in,
  output logic               cmp_pos_out,
  output logic               preset_out,
  output logic               zero_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int t = 0;
  always @(posedge sys_clk_in) t <= (sw_in.ref_fast || sw_in.ref_slow) ? t + 1 : 0;
  assign cmp_pos_out = pos_in;
  // Long fast slope drives the count into saturation
  assign preset_out = !full_in || (sw_in.ref_fast && t > 600);
  // Slow slope long enough to carry the low bits into saturation
  assign zero_out = !full_in || (sw_in.ref_slow && t > 200);
endmodule // tsa_front_model

// >>> test/tb_top.sv
// Testbench for the triple-slope sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, trig_n = 1, full = 0, pos = 0, cp, pl, zr, busy, done;
  tsa_pkg::tsa_result_t res;
  tsa_pkg::tsa_switch_t sw;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  tsa_sequencer #(.INTEG_CYCLES(20), .SETTLE_CYCLES(2)) uut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .trigger_n_in(trig_n), .input_positive_in(cp), .preset_level_in(pl), .zero_return_input(zr),
    .result_out(res), .switch_out(sw), .busy_out(busy), .done_out(done));
  tsa_front_model fm (.sys_clk_in(clk), .full_in(full), .pos_in(pos), .sw_in(sw),
    .cmp_pos_out(cp), .preset_out(pl), .zero_out(zr));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (++cyc == 20000) begin
    num_errors++;
    wrap_up();
  end
  task automatic chk(input tsa_pkg::tsa_result_t e);
    samples_checked++;
    if (res !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, res, e);
    end
  endtask
  task automatic chk_bit(input logic g, e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic convert(input logic f, p);
    int i;
    repeat (50) @(posedge clk);
    full <= f;
    pos <= p;
    trig_n <= 0;
    repeat (13) @(posedge clk);
    trig_n <= 1;
    repeat (3) @(negedge clk);
    chk_bit(busy, 1'b1);
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
    chk_bit(busy, 1'b0);
    chk_bit(sw.ref_negative, p);
  endtask
  task automatic t_pos_full();
    convert(1'b1, 1'b1);
    chk({1'b1, 16'hffff});
    $display("pos full done");
  endtask
  task automatic t_zero();
    convert(1'b0, 1'b1);
    chk({1'b1, 16'h0000});
    $display("zero done");
  endtask
  task automatic t_neg_full();
    convert(1'b1, 1'b0);
    chk({1'b0, 16'hffff});
    $display("neg full done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_pos_full();
    t_zero();
    t_neg_full();
    wrap_up();
  end
endmodule // tb_top
